// ---- dv/fsps_cpu_model.sv ----
// cpu-side partner: pulses halt and times the sequencer's release
// assumes the sequencer shares its clock and answers with a release pulse
module fsps_cpu_model (
    input  wire logic i_clk,
    input  wire logic i_release,
    input  wire logic i_stall,
    output logic      o_halt
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_halt = 1'b0;
    // one halt pulse, then count edges until release, stall must cover the wait
    task automatic run_halt(input int lim, output int n, output bit ok);
        ok = 1'b1;
        n  = 0;
        @(posedge i_clk);
        o_halt <= 1'b1;
        @(posedge i_clk);
        o_halt <= 1'b0;
        // bounded wait, a hang shows up as a wrong count
        while (n < lim) begin
            @(posedge i_clk);
            n++;
            if (i_release === 1'b1) break;
            if (i_stall !== 1'b1) ok = 1'b0;
        end
        if (i_stall !== 1'b0) ok = 1'b0;
        // settle time before the next command, 160 cycles, less than the 200-cycle entry wait
        repeat (160) @(posedge i_clk);
    endtask : run_halt
endmodule : fsps_cpu_model

// ---- dv/fsps_top_tb.sv ----
// self-checking bench for the self-programming sequencer
// assumes long operation counts cut to 300 cycles by parameter
`include "fsps_consts.svh"
module fsps_top_tb import fsps_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, arst_n, halt, irq, ack, rel, stall, iblk, phold, irq_out, irq_seen;
    fsps_wb_req_t req;
    logic [31:0]  dat;
    int           n_fail, tests_run, n;
    bit           ok;
    fsps_top #(.VFY1_CYC(300), .ERASE_CYC(300), .BLANK_CYC(300)) fsps_top_inst (
        .I_CLK_SYS(clk), .I_ARST_N(arst_n), .I_WB_REQ(req), .O_WB_ACK(ack),
        .O_WB_DAT(dat), .I_HALT(halt), .I_IRQ(irq), .O_HALT_RELEASE(rel),
        .O_CPU_STALL(stall), .O_INT_BLOCK(iblk), .O_PIN_HOLD(phold), .O_IRQ_OUT(irq_out));
    fsps_cpu_model fsps_cpu_model_inst (
        .i_clk(clk), .i_release(rel), .i_stall(stall), .o_halt(halt));
    // 20 MHz clock
    always #25 clk = ~clk;
    // latch any forwarded interrupt, the pulse may be short
    always @(posedge clk) if (irq_out === 1'b1) irq_seen <= 1'b1;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task complete_run;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [15:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
        int k;
        k = 0;
        @(posedge clk);
        req <= '{1'b1, 1'b1, we, 4'hF, {idx, 2'b00}, {24'h000000, wd}};
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (ack !== 1'b1) begin
            n_fail++;
            complete_run();
        end
        rd = dat[7:0];
        req <= '0;
    endtask : wb
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [7:0] x;
        wb(1'b1, idx, d, x);
    endtask : wr
    task automatic rdc(input logic [15:0] idx, input logic [7:0] exp, input logic [7:0] m);
        logic [7:0] x;
        wb(1'b0, idx, 8'h00, x);
        check({24'h000000, x & m}, {24'h000000, exp});
    endtask : rdc
    // key, value, inverse, value
    task automatic set_mode(input logic [7:0] v);
        wr(`FSPS_IDX_UNLOCK, `FSPS_UNLOCK_KEY);
        wr(`FSPS_IDX_MODE, v);
        wr(`FSPS_IDX_MODE, ~v);
        wr(`FSPS_IDX_MODE, v);
    endtask : set_mode
    // load a command, halt, then check release time and stall cover
    task automatic op(input logic [7:0] cmd, input int exp_n);
        wr(`FSPS_IDX_CMD, cmd);
        fsps_cpu_model_inst.run_halt(5000, n, ok);
        check(32'(n), 32'(exp_n));
        check({31'h0, ok}, 32'h00000001);
    endtask : op
    initial begin
        clk = 1'b0; arst_n = 1'b0; irq = 1'b0; irq_seen = 1'b0; req = '0;
        n_fail = 0; tests_run = 0;
        // erased flash, protect byte locks block 0
        for (int i = 0; i < 1024; i++) begin
            fsps_top_inst.mem[i] = `FSPS_BLANK;
            fsps_top_inst.bad[i] = 1'b0;
        end
        fsps_top_inst.mem[`FSPS_PROT_ADDR] = 8'h01;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rdc(`FSPS_IDX_MODE, 8'h00, 8'h01);
        rdc(`FSPS_IDX_ERR, 8'h00, 8'hFF);
        rdc(`FSPS_IDX_MODE, 8'h04, 8'h7C);
        $display("reset test done");
        // inverse step wrong: refused and flagged
        wr(`FSPS_IDX_UNLOCK, `FSPS_UNLOCK_KEY);
        wr(`FSPS_IDX_MODE, 8'h01);
        wr(`FSPS_IDX_MODE, 8'h01);
        wr(`FSPS_IDX_MODE, 8'h01);
        rdc(`FSPS_IDX_MODE, 8'h00, 8'h01);
        rdc(`FSPS_IDX_ERR, 8'h01, 8'h01);
        wr(`FSPS_IDX_ERR, 8'h00);
        rdc(`FSPS_IDX_ERR, 8'h00, 8'h01);
        fsps_cpu_model_inst.run_halt(300, n, ok);
        check(32'(n), 32'd300);
        $display("protect test done");
        set_mode(8'h01);
        rdc(`FSPS_IDX_MODE, 8'h01, 8'h01);
        check({30'h0, iblk, phold}, 32'h00000003);
        fsps_cpu_model_inst.run_halt(1000, n, ok);
        check(32'(n), 32'd200);
        @(posedge clk) irq <= 1'b1;
        @(posedge clk) irq <= 1'b0;
        repeat (4) @(posedge clk);
        check({31'h0, irq_seen}, 32'h00000000);
        wr(`FSPS_IDX_APH, 8'h02);
        wr(`FSPS_IDX_APL, 8'hF5);
        wr(`FSPS_IDX_CPH, 8'h02);
        wr(`FSPS_IDX_CPL, 8'hF5);
        wr(`FSPS_IDX_WBUF, 8'h3C);
        op(`FSPS_CMD_WRITE, 3000);
        rdc(16'h02F5, 8'h3C, 8'hFF);
        op(`FSPS_CMD_VFY2, 540);
        op(`FSPS_CMD_VFY1, 300);
        rdc(`FSPS_IDX_ERR, 8'h00, 8'hFF);
        op(`FSPS_CMD_ERASE, 300);
        rdc(16'h02F5, `FSPS_BLANK, 8'hFF);
        op(`FSPS_CMD_BLANK, 300);
        op(8'h07, 2);
        wr(`FSPS_IDX_CPL, 8'hF8);
        op(`FSPS_CMD_VFY2, 2160);
        rdc(`FSPS_IDX_ERR, 8'h00, 8'hFF);
        $display("command test done");
        // rewrite without erase leaves a bad byte
        wr(`FSPS_IDX_WBUF, 8'hC3);
        op(`FSPS_CMD_WRITE, 3000);
        wr(`FSPS_IDX_WBUF, 8'h3C);
        op(`FSPS_CMD_WRITE, 3000);
        op(`FSPS_CMD_VFY2, 2160);
        rdc(`FSPS_IDX_ERR, 8'h02, 8'h02);
        wr(`FSPS_IDX_ERR, 8'h00);
        rdc(`FSPS_IDX_ERR, 8'h00, 8'h02);
        // block 0 is locked by the protect byte: erase refused and flagged
        wr(`FSPS_IDX_APH, 8'h00);
        op(`FSPS_CMD_ERASE, 300);
        rdc(`FSPS_IDX_ERR, 8'h04, 8'h04);
        rdc(`FSPS_PROT_ADDR, 8'h01, 8'hFF);
        wr(`FSPS_IDX_CMD, 8'h00);
        set_mode(8'h00);
        repeat (4) @(posedge clk);
        rdc(`FSPS_IDX_MODE, 8'h00, 8'h01);
        check({30'h0, iblk, irq_seen}, 32'h00000001);
        $display("exit test done");
        complete_run();
    end
endmodule : fsps_top_tb

// ---- verilog/fsps_consts.svh ----
// constants for the flash self-programming sequencer
// assumes a 20 MHz system clock and 8-bit registers on word-spaced indexes
`ifndef FSPS_CONSTS_SVH
`define FSPS_CONSTS_SVH
// register indexes, byte address is four times the index
`define FSPS_IDX_UNLOCK 16'hFFA0
`define FSPS_IDX_ERR    16'hFFA1
`define FSPS_IDX_MODE   16'hFFA2
`define FSPS_IDX_CMD    16'hFFA3
`define FSPS_IDX_APL    16'hFFA4
`define FSPS_IDX_APH    16'hFFA5
`define FSPS_IDX_CPL    16'hFFA6
`define FSPS_IDX_CPH    16'hFFA7
`define FSPS_IDX_WBUF   16'hFFA8
`define FSPS_IDX_STAT   16'hFFA9
// field values
`define FSPS_UNLOCK_KEY 8'hA5
`define FSPS_BLANK      8'hFF
`define FSPS_PROT_ADDR  16'h0081
// command codes
`define FSPS_CMD_VFY1   8'h01
`define FSPS_CMD_VFY2   8'h02
`define FSPS_CMD_ERASE  8'h03
`define FSPS_CMD_BLANK  8'h04
`define FSPS_CMD_WRITE  8'h05
// timing, in microseconds, and clock rate
`define FSPS_CLK_MHZ    20
`define FSPS_VFY1_US    6800
`define FSPS_VFY2_US    27
`define FSPS_ERASE_US   8500
`define FSPS_BLANK_US   480
`define FSPS_WRITE_US   150
`define FSPS_ENTRY_US   10
`endif

// ---- verilog/fsps_pkg.sv ----
// types shared by the flash self-programming sequencer
// assumes the constants header sits beside it
package fsps_pkg;
    // one classic wishbone request
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [17:0] adr;
        logic [31:0] dat;
    } fsps_wb_req_t;
    // protected mode-write sequence
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_KEY, SEQ_VAL, SEQ_INV} fsps_seq_t;
    // operation sequencer
    typedef enum logic [1:0] {OP_IDLE, OP_WALK, OP_WAIT} fsps_op_t;
endpackage : fsps_pkg

// ---- verilog/fsps_top.sv ----
// flash self-programming sequencer with flash array and wishbone slave
// assumes a cpu on the same clock that pulses halt and obeys stall
// Behaviour
// - halt in mode starts loaded operation
// - operation end pulses halt release itself
// - mode entry only through protected write
// - maskable interrupts blocked in mode
// - block verify done 6.8 ms after halt
// - in-block verify 27 us per byte
// - block erase done 8.5 ms after halt
// - erased bytes read all ones
// - blank check done 480 us after halt
// - byte write done 150 us after halt
// - cpu stalled while command runs
// - interrupts pend until mode is left
// - no ram access while command runs
// - entry halt released within 10 us
// - pins hold halt state in mode
// - only protect byte blocks write/erase
// - written flash readable through bus
// - mode bit clear after reset
// - key, value, inverse, value order
// - bad order sets error, mode unchanged
// - protect byte loaded after reset
`include "fsps_consts.svh"
module fsps_top import fsps_pkg::*; #(
    parameter int unsigned AW        = 10,
    parameter int unsigned BLK_BITS  = 8,
    parameter int unsigned VFY1_CYC  = `FSPS_VFY1_US * `FSPS_CLK_MHZ,
    parameter int unsigned ERASE_CYC = `FSPS_ERASE_US * `FSPS_CLK_MHZ,
    parameter int unsigned BLANK_CYC = `FSPS_BLANK_US * `FSPS_CLK_MHZ
) (
    input  wire logic         I_CLK_SYS,
    input  wire logic         I_ARST_N,
    input  wire fsps_wb_req_t I_WB_REQ,
    output logic              O_WB_ACK,
    output logic [31:0]       O_WB_DAT,
    input  wire logic         I_HALT,
    input  wire logic         I_IRQ,
    output logic              O_HALT_RELEASE,
    output logic              O_CPU_STALL,
    output logic              O_INT_BLOCK,
    output logic              O_PIN_HOLD,
    output logic              O_IRQ_OUT
);
    localparam int unsigned DEPTH     = 1 << AW;
    localparam int unsigned WRITE_CYC = `FSPS_WRITE_US * `FSPS_CLK_MHZ;
    localparam int unsigned VFY2_CYC  = `FSPS_VFY2_US * `FSPS_CLK_MHZ;
    localparam int unsigned ENTRY_CYC = `FSPS_ENTRY_US * `FSPS_CLK_MHZ;

    // timer load so that release shows n cycles after the halt cycle
    function automatic logic [31:0] ld(input logic [31:0] n);
        ld = n - 32'h2;
    endfunction : ld

    logic [7:0]    mem [DEPTH];          // flash array
    logic          bad [DEPTH];          // byte failed to program
    logic          ack_ff, nxt_ack;      // bus answer
    logic [31:0]   rd_ff, nxt_rd;        // read data
    logic          mode_ff, nxt_mode;    // self_prog_select
    logic [4:0]    prot_ff, nxt_prot;    // protect byte bits
    logic          pld_ff, nxt_pld;      // protect byte loaded
    logic [2:0]    err_ff, nxt_err;      // wepr, verify, sequence
    fsps_seq_t     seq_ff, nxt_seq;      // unlock progress
    logic          val_ff, nxt_val;      // value being written
    logic [7:0]    cmd_ff, nxt_cmd;      // prog_command_reg
    logic [7:0]    apl_ff, nxt_apl;      // addr_ptr_low
    logic [7:0]    aph_ff, nxt_aph;      // addr_ptr_high
    logic [7:0]    cpl_ff, nxt_cpl;      // addr_cmp_low
    logic [7:0]    cph_ff, nxt_cph;      // addr_cmp_high
    logic [7:0]    wbuf_ff, nxt_wbuf;    // write_buffer
    fsps_op_t      op_ff, nxt_op;        // sequencer state
    logic          ent_ff, nxt_ent;      // entry halt still owed
    logic [7:0]    kind_ff, nxt_kind;    // running command
    logic          blk_ff, nxt_blk;      // command blocked by protect
    logic [31:0]   tmr_ff, nxt_tmr;      // cycles to release
    logic [AW-1:0] ptr_ff, nxt_ptr;      // walk pointer
    logic [AW-1:0] end_ff, nxt_end;      // walk bound
    logic          rel_ff, nxt_rel;      // halt release pulse
    logic          stl_ff, nxt_stl;      // cpu stall
    logic          pnd_ff, nxt_pnd;      // interrupt held in mode
    logic          irq_ff, nxt_irq;      // forwarded interrupt
    logic          mem_we;               // array write strobe
    logic [AW-1:0] mem_wa;               // array write address
    logic [7:0]    mem_wd;               // array write data
    logic          bad_wd;               // fail mark written
    logic [15:0]   idx;                  // register index
    logic          hit, wr;              // bus strobes
    logic [AW-1:0] adr, cad, base;       // operand addresses
    logic          prot_hit;             // target block protected

    assign idx  = I_WB_REQ.adr[17:2];
    assign hit  = I_WB_REQ.cyc && I_WB_REQ.stb;
    // writes land only at the edge where ack is seen
    assign wr   = hit && I_WB_REQ.we && ack_ff && I_WB_REQ.sel[0];
    // upper pointer bits beyond the array are dropped on purpose
    assign adr  = AW'({aph_ff, apl_ff});
    assign cad  = AW'({cph_ff, cpl_ff});
    assign base = adr & ~AW'((1 << BLK_BITS) - 1);
    // low blocks below the protect value are locked
    assign prot_hit = 32'(adr >> BLK_BITS) < 32'(prot_ff);

    // bus slave: ack one cycle after the strobe, data ready with it
    always_comb begin
        nxt_ack = hit && !ack_ff;
        nxt_rd  = rd_ff;
        if (hit && !ack_ff) begin
            nxt_rd = 32'h0;                  // unmapped reads zero
            case (idx)
                `FSPS_IDX_ERR:  nxt_rd[2:0] = err_ff;
                `FSPS_IDX_MODE: nxt_rd[7:0] = {1'b0, prot_ff, 1'b0, mode_ff};
                `FSPS_IDX_CMD:  nxt_rd[7:0] = cmd_ff;
                `FSPS_IDX_APL:  nxt_rd[7:0] = apl_ff;
                `FSPS_IDX_APH:  nxt_rd[7:0] = aph_ff;
                `FSPS_IDX_CPL:  nxt_rd[7:0] = cpl_ff;
                `FSPS_IDX_CPH:  nxt_rd[7:0] = cph_ff;
                `FSPS_IDX_WBUF: nxt_rd[7:0] = wbuf_ff;
                `FSPS_IDX_STAT: nxt_rd[0]   = stl_ff;
                default: begin
                    if (32'(idx) < DEPTH) begin
                        nxt_rd[7:0] = mem[idx[AW-1:0]];
                    end
                end
            endcase
        end
    end

    // protected mode write, plain registers and error flags
    always_comb begin
        logic [2:0] set;
        logic [2:0] clr;
        set      = 3'h0;
        clr      = 3'h0;
        nxt_seq  = seq_ff;
        nxt_val  = val_ff;
        nxt_mode = mode_ff;
        nxt_cmd  = cmd_ff;
        nxt_apl  = apl_ff;
        nxt_aph  = aph_ff;
        nxt_cpl  = cpl_ff;
        nxt_cph  = cph_ff;
        nxt_wbuf = wbuf_ff;
        nxt_pld  = 1'b1;
        // protect byte captured once, after reset is released
        nxt_prot = pld_ff ? prot_ff : mem[AW'(`FSPS_PROT_ADDR)][4:0];
        if (wr) begin
            // any other store breaks a pending sequence
            if (seq_ff != SEQ_IDLE && idx != `FSPS_IDX_MODE) begin
                set[0]  = 1'b1;
                nxt_seq = SEQ_IDLE;
            end
            case (idx)
                `FSPS_IDX_UNLOCK: begin
                    if (I_WB_REQ.dat[7:0] == `FSPS_UNLOCK_KEY) begin
                        nxt_seq = SEQ_KEY;
                    end
                end
                `FSPS_IDX_MODE: begin
                    nxt_seq = SEQ_IDLE;
                    case (seq_ff)
                        SEQ_KEY: begin
                            nxt_val = I_WB_REQ.dat[0];
                            nxt_seq = SEQ_VAL;
                        end
                        SEQ_VAL: begin
                            if (I_WB_REQ.dat[0] == !val_ff) begin
                                nxt_seq = SEQ_INV;
                            end else begin
                                set[0] = 1'b1;
                            end
                        end
                        SEQ_INV: begin
                            if (I_WB_REQ.dat[0] == val_ff) begin
                                nxt_mode = val_ff;
                            end else begin
                                set[0] = 1'b1;
                            end
                        end
                        default: set[0] = 1'b1;
                    endcase
                end
                `FSPS_IDX_ERR:  clr = ~I_WB_REQ.dat[2:0];
                `FSPS_IDX_CMD:  nxt_cmd = I_WB_REQ.dat[7:0];
                `FSPS_IDX_APL:  nxt_apl = I_WB_REQ.dat[7:0];
                `FSPS_IDX_APH:  nxt_aph = I_WB_REQ.dat[7:0];
                `FSPS_IDX_CPL:  nxt_cpl = I_WB_REQ.dat[7:0];
                `FSPS_IDX_CPH:  nxt_cph = I_WB_REQ.dat[7:0];
                `FSPS_IDX_WBUF: nxt_wbuf = I_WB_REQ.dat[7:0];
                default: ;
            endcase
        end
        // hardware errors from the sequencer
        if (op_ff == OP_IDLE && nxt_op != OP_IDLE && nxt_blk) begin
            set[2] = 1'b1;
        end
        if (op_ff == OP_WALK) begin
            if ((kind_ff == `FSPS_CMD_BLANK && mem[ptr_ff] != `FSPS_BLANK) ||
                (kind_ff != `FSPS_CMD_BLANK && kind_ff != `FSPS_CMD_ERASE &&
                 bad[ptr_ff])) begin
                set[1] = 1'b1;
            end
        end
        // a hardware set wins over a software clear
        nxt_err = (err_ff & ~clr) | set;
    end

    // operation sequencer: start on halt, walk, wait, release
    always_comb begin
        logic [31:0] cnt;
        cnt      = 32'(cad - adr) + 32'h1;
        nxt_op   = op_ff;
        nxt_ent  = ent_ff || (!mode_ff && nxt_mode);
        nxt_kind = kind_ff;
        nxt_blk  = blk_ff;
        nxt_tmr  = tmr_ff;
        nxt_ptr  = ptr_ff;
        nxt_end  = end_ff;
        nxt_rel  = 1'b0;
        mem_we   = 1'b0;
        mem_wa   = ptr_ff;
        mem_wd   = `FSPS_BLANK;
        bad_wd   = 1'b0;
        case (op_ff)
            OP_IDLE: begin
                if (I_HALT && mode_ff) begin
                    nxt_op   = OP_WAIT;
                    nxt_kind = cmd_ff;
                    nxt_blk  = 1'b0;
                    nxt_ptr  = base;
                    nxt_end  = base + AW'((1 << BLK_BITS) - 1);
                    nxt_tmr  = ld(32'h2);
                    if (ent_ff) begin
                        nxt_ent  = 1'b0;
                        nxt_kind = 8'h00;
                        nxt_tmr  = ld(ENTRY_CYC);
                    end else begin
                        case (cmd_ff)
                            `FSPS_CMD_WRITE: begin
                                nxt_blk = prot_hit;
                                nxt_tmr = ld(WRITE_CYC);
                                mem_we  = !prot_hit;
                                mem_wa  = adr;
                                mem_wd  = mem[adr] & wbuf_ff;
                                bad_wd  = (mem[adr] & wbuf_ff) != wbuf_ff;
                            end
                            `FSPS_CMD_ERASE: begin
                                nxt_blk = prot_hit;
                                nxt_op  = prot_hit ? OP_WAIT : OP_WALK;
                                nxt_tmr = ld(ERASE_CYC);
                            end
                            `FSPS_CMD_BLANK: begin
                                nxt_op  = OP_WALK;
                                nxt_tmr = ld(BLANK_CYC);
                            end
                            `FSPS_CMD_VFY1: begin
                                nxt_op  = OP_WALK;
                                nxt_tmr = ld(VFY1_CYC);
                            end
                            `FSPS_CMD_VFY2: begin
                                nxt_op  = OP_WALK;
                                nxt_ptr = adr;
                                // compare below pointer checks one byte
                                nxt_end = (cad < adr) ? adr : cad;
                                cnt     = (cad < adr) ? 32'h1 : cnt;
                                nxt_tmr = ld(VFY2_CYC * cnt);
                            end
                            default: ;
                        endcase
                    end
                end
            end
            OP_WALK: begin
                nxt_tmr = tmr_ff - 32'h1;
                mem_we  = kind_ff == `FSPS_CMD_ERASE;
                nxt_ptr = ptr_ff + AW'(1);
                if (ptr_ff == end_ff) begin
                    nxt_op = OP_WAIT;
                end
            end
            OP_WAIT: begin
                nxt_tmr = tmr_ff - 32'h1;
                if (tmr_ff == 32'h0) begin
                    nxt_op  = OP_IDLE;
                    nxt_rel = 1'b1;
                end
            end
            default: nxt_op = OP_IDLE;
        endcase
        nxt_stl = nxt_op != OP_IDLE;
        // requests in mode are held and replayed on leaving it
        nxt_pnd = mode_ff && (pnd_ff || I_IRQ);
        nxt_irq = !mode_ff && (pnd_ff || I_IRQ);
    end

    // flash array has no reset, it holds its contents
    // plain always so the contents may be preloaded from outside
    always @(posedge I_CLK_SYS) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
            bad[mem_wa] <= bad_wd;
        end
    end

    // all control state
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ack_ff <= 1'b0;  rd_ff <= 32'h0;  mode_ff <= 1'b0;
            prot_ff <= 5'h0; pld_ff <= 1'b0;  err_ff <= 3'h0;
            seq_ff <= SEQ_IDLE; val_ff <= 1'b0; cmd_ff <= 8'h00;
            apl_ff <= 8'h00; aph_ff <= 8'h00; cpl_ff <= 8'h00;
            cph_ff <= 8'h00; wbuf_ff <= 8'h00; op_ff <= OP_IDLE;
            ent_ff <= 1'b0;  kind_ff <= 8'h00; blk_ff <= 1'b0;
            tmr_ff <= 32'h0; ptr_ff <= '0;    end_ff <= '0;
            rel_ff <= 1'b0;  stl_ff <= 1'b0;  pnd_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            ack_ff <= nxt_ack;  rd_ff <= nxt_rd;  mode_ff <= nxt_mode;
            prot_ff <= nxt_prot; pld_ff <= nxt_pld; err_ff <= nxt_err;
            seq_ff <= nxt_seq;  val_ff <= nxt_val; cmd_ff <= nxt_cmd;
            apl_ff <= nxt_apl;  aph_ff <= nxt_aph; cpl_ff <= nxt_cpl;
            cph_ff <= nxt_cph;  wbuf_ff <= nxt_wbuf; op_ff <= nxt_op;
            ent_ff <= nxt_ent;  kind_ff <= nxt_kind; blk_ff <= nxt_blk;
            tmr_ff <= nxt_tmr;  ptr_ff <= nxt_ptr; end_ff <= nxt_end;
            rel_ff <= nxt_rel;  stl_ff <= nxt_stl; pnd_ff <= nxt_pnd;
            irq_ff <= nxt_irq;
        end
    end

    assign O_WB_ACK       = ack_ff;
    assign O_WB_DAT       = rd_ff;
    assign O_HALT_RELEASE = rel_ff;
    assign O_CPU_STALL    = stl_ff;
    assign O_INT_BLOCK    = mode_ff;
    assign O_PIN_HOLD     = mode_ff;
    assign O_IRQ_OUT      = irq_ff;

    // cycles since the starting halt, for the checks below
    logic [31:0] hlp_ff;
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            hlp_ff <= 32'h0;
        end else begin
            hlp_ff <= (op_ff == OP_IDLE) ? 32'h1 : hlp_ff + 32'h1;
        end
    end

    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_ARST_N);

    sequence s_entry_halt;
        op_ff == OP_IDLE && I_HALT && mode_ff && ent_ff;
    endsequence
    sequence s_release_200;
        !O_HALT_RELEASE [*8] ##192 O_HALT_RELEASE;
    endsequence

    AST_HALT_START: assert property (
        op_ff == OP_IDLE && I_HALT && mode_ff |=> O_CPU_STALL)
        else $error("halt in mode did not start the sequencer");
    AST_ENTRY_REL: assert property (s_entry_halt |-> ##1 s_release_200)
        else $error("entry halt not released after 200 cycles");
    AST_WRITE_TIME: assert property (
        $rose(O_HALT_RELEASE) && kind_ff == `FSPS_CMD_WRITE |-> hlp_ff == WRITE_CYC)
        else $error("byte write time wrong");
    AST_ERASE_TIME: assert property (
        $rose(O_HALT_RELEASE) && kind_ff == `FSPS_CMD_ERASE |-> hlp_ff == ERASE_CYC)
        else $error("block erase time wrong");
    AST_BLANK_TIME: assert property (
        $rose(O_HALT_RELEASE) && kind_ff == `FSPS_CMD_BLANK |-> hlp_ff == BLANK_CYC)
        else $error("blank check time wrong");
    AST_VFY1_TIME: assert property (
        $rose(O_HALT_RELEASE) && kind_ff == `FSPS_CMD_VFY1 |-> hlp_ff == VFY1_CYC)
        else $error("block verify time wrong");
    AST_ERASED_FF: assert property (
        op_ff == OP_WALK && kind_ff == `FSPS_CMD_ERASE |=>
        mem[$past(ptr_ff)] == `FSPS_BLANK)
        else $error("erased byte not blank");
    AST_MODE_SEQ: assert property (
        $changed(mode_ff) |-> $past(seq_ff) == SEQ_INV)
        else $error("mode changed outside the unlock sequence");
    AST_SEQ_ERR: assert property (
        wr && idx == `FSPS_IDX_MODE && seq_ff == SEQ_IDLE |=>
        err_ff[0] && $stable(mode_ff))
        else $error("unprotected mode write not flagged");
    AST_IRQ_HELD: assert property (O_IRQ_OUT |-> !$past(mode_ff))
        else $error("interrupt passed during mode");
    AST_IRQ_PEND: assert property ($fell(mode_ff) && pnd_ff |=> O_IRQ_OUT)
        else $error("pending interrupt lost");
    AST_STALL: assert property (O_HALT_RELEASE |-> !O_CPU_STALL && $past(O_CPU_STALL))
        else $error("release without prior stall");
endmodule : fsps_top
